// ---- shared/timer16_params.svh ----
// Purpose: constants of the 16-bit pwm timer block
// Assumes: included by bare name
// Notes:   offsets are byte addresses on the axi4-lite register bus
`ifndef TIMER16_PARAMS_SVH
`define TIMER16_PARAMS_SVH
// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define T16_OFS_CTRL     8'h00
`define T16_OFS_COUNT    8'h04
`define T16_OFS_CMP_A    8'h08
`define T16_OFS_CMP_B    8'h0C
`define T16_OFS_CAPTURE  8'h10
`define T16_OFS_FLAGS    8'h14
`define T16_OFS_PRESCALE 8'h18
// ----------------------------------------------------------------------------
// control field positions and fixed tops
// ----------------------------------------------------------------------------
`define T16_WGM_LSB      0
`define T16_COMA_LSB     4
`define T16_COMB_LSB     6
`define T16_TOP_8BIT     16'h00FF
`define T16_TOP_9BIT     16'h01FF
`define T16_TOP_10BIT    16'h03FF
`define T16_MAX          16'hFFFF
`define T16_BOTTOM       16'h0000
`define T16_FLAG_OVF     0
`define T16_FLAG_CMPA    1
`define T16_FLAG_CMPB    2
`define T16_FLAG_CAP     3
`define T16_RESP_OKAY    2'h0
`define T16_RESP_SLVERR  2'h2
`endif

// ---- shared/timer16_pkg.sv ----
// Purpose: types of the 16-bit pwm timer block
// Assumes: nothing
// Notes:   waveform mode codes are the documented 4-bit values
package timer16_pkg;
   typedef enum logic [3:0] {
      WGM_NORMAL   = 4'h0,
      WGM_PC8      = 4'h1,
      WGM_PC9      = 4'h2,
      WGM_PC10     = 4'h3,
      WGM_FAST8    = 4'h5,
      WGM_FAST9    = 4'h6,
      WGM_FAST10   = 4'h7,
      WGM_PC_CAP   = 4'hA,
      WGM_PC_CMPA  = 4'hB,
      WGM_FAST_CAP = 4'hE,
      WGM_FAST_CMP = 4'hF
   } waveform_mode_t;
   typedef enum logic [1:0] {
      ACT_OFF    = 2'h0,
      ACT_TOGGLE = 2'h1,
      ACT_CLEAR  = 2'h2,
      ACT_SET    = 2'h3
   } output_action_t;
endpackage

// ---- verilog/timer16_pwm.sv ----
// Purpose: fast and phase-correct pwm waveform generator of a 16-bit timer
// Assumes: axi4-lite slave, one clock, synchronous active-low reset
// Notes:   includes its own prescaler producing the timer clock enable
// Operation
// - fast pwm top: fixed 8/9/10-bit ones, capture reg (14) or compare a (15)
// - fast pwm counts up from bottom, returns to bottom cycle after top
// - fast pwm raises overflow flag each time counter reaches top
// - register-defined top raises compare-a or capture flag with overflow flag
// - fixed top modes mask compare bits above top width on write
// - capture reg as top is unbuffered; missed top runs to max and wraps
// - compare a writes buffered, loaded when count matches top
// - fast pwm mode two clears on match, sets at bottom; three opposite
// - fast pwm period is top plus one timer clock cycles
// - compare zero gives spike; compare equal top gives constant level
// - mode 15 with toggle action gives 50% square wave on output a
// - phase-correct modes 1,2,3,10,11 count up to top then down
// - phase-correct top fixed for 1..3, capture for 10, compare a for 11
// - phase-correct count turns at top without holding it an extra timer cycle
// - phase-correct non-inverting clears on up match, sets on down match
// - phase-correct raises overflow flag at bottom
// - phase-correct loads compare buffers at top, flags register top there
// - each compare unit flags when counter equals its compare register
// - phase-correct period is twice top timer cycles
// - phase-correct non-inverting compare at bottom keeps low, at top keeps high
// - mode 11 with toggle action gives 50% duty on output a
//
// Local design decisions: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "timer16_params.svh"
module timer16_pwm #(
   parameter int ADDR_W = 8
) (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   output logic                   wave_out_a,
   output logic                   wave_out_b,
   output logic                   overflow_flag,
   output logic                   compare_a_flag,
   output logic                   capture_flag
);
   // ------------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------------
   logic [3:0]          waveform_mode_reg;
   logic [1:0]          output_action_mode_a_reg;
   logic [1:0]          output_action_mode_b_reg;
   logic [15:0]         counter_value_reg;
   logic                count_down_reg;
   logic [15:0]         compare_reg_a_reg;
   logic [15:0]         compare_reg_b_reg;
   logic [15:0]         compare_buf_a_reg;
   logic [15:0]         compare_buf_b_reg;
   logic [15:0]         capture_reg_reg;
   logic [3:0]          flags_reg;
   logic [15:0]         prescale_div_reg;
   logic [15:0]         prescale_cnt_reg;
   logic                tick_reg;
   logic                aw_held_reg;
   logic                w_held_reg;
   logic [ADDR_W-1:0]   aw_addr_reg;
   logic [31:0]         w_data_reg;
   logic [3:0]          w_strb_reg;

   // ------------------------------------------------------------------------
   // mode decode
   // ------------------------------------------------------------------------
   logic        is_fast;
   logic        is_pc;
   logic        top_is_cmpa;
   logic        top_is_cap;
   logic [15:0] top_value;
   logic [15:0] fixed_mask;
   always_comb begin
      is_fast     = 1'b0;
      is_pc       = 1'b0;
      top_is_cmpa = 1'b0;
      top_is_cap  = 1'b0;
      top_value   = `T16_MAX;
      fixed_mask  = `T16_MAX;
      case (timer16_pkg::waveform_mode_t'(waveform_mode_reg))
         timer16_pkg::WGM_FAST8: begin
            is_fast = 1'b1; top_value = `T16_TOP_8BIT; fixed_mask = `T16_TOP_8BIT;
         end
         timer16_pkg::WGM_FAST9: begin
            is_fast = 1'b1; top_value = `T16_TOP_9BIT; fixed_mask = `T16_TOP_9BIT;
         end
         timer16_pkg::WGM_FAST10: begin
            is_fast = 1'b1; top_value = `T16_TOP_10BIT; fixed_mask = `T16_TOP_10BIT;
         end
         timer16_pkg::WGM_FAST_CAP: begin
            is_fast = 1'b1; top_is_cap = 1'b1; top_value = capture_reg_reg;
         end
         timer16_pkg::WGM_FAST_CMP: begin
            is_fast = 1'b1; top_is_cmpa = 1'b1; top_value = compare_reg_a_reg;
         end
         timer16_pkg::WGM_PC8: begin
            is_pc = 1'b1; top_value = `T16_TOP_8BIT; fixed_mask = `T16_TOP_8BIT;
         end
         timer16_pkg::WGM_PC9: begin
            is_pc = 1'b1; top_value = `T16_TOP_9BIT; fixed_mask = `T16_TOP_9BIT;
         end
         timer16_pkg::WGM_PC10: begin
            is_pc = 1'b1; top_value = `T16_TOP_10BIT; fixed_mask = `T16_TOP_10BIT;
         end
         timer16_pkg::WGM_PC_CAP: begin
            is_pc = 1'b1; top_is_cap = 1'b1; top_value = capture_reg_reg;
         end
         timer16_pkg::WGM_PC_CMPA: begin
            is_pc = 1'b1; top_is_cmpa = 1'b1; top_value = compare_reg_a_reg;
         end
         default: is_fast = 1'b0; // other modes: counter stands still
      endcase
   end

   logic at_top;
   logic at_bottom;
   logic match_a;
   logic match_b;
   logic tick;
   assign tick      = tick_reg;
   assign at_top    = (counter_value_reg == top_value);
   assign at_bottom = (counter_value_reg == `T16_BOTTOM);
   assign match_a   = (counter_value_reg == compare_reg_a_reg);
   assign match_b   = (counter_value_reg == compare_reg_b_reg);

   // ------------------------------------------------------------------------
   // prescaler: tick once every prescale_div_reg+1 clocks
   // ------------------------------------------------------------------------
   // software picks the divide minus one (0,7,63,255,1023 for the usual set)
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prescale_cnt_reg <= `T16_BOTTOM;
         tick_reg         <= 1'b0;
      end else if (prescale_cnt_reg >= prescale_div_reg) begin
         prescale_cnt_reg <= `T16_BOTTOM;
         tick_reg         <= 1'b1;
      end else begin
         prescale_cnt_reg <= prescale_cnt_reg + 16'h0001;
         tick_reg         <= 1'b0;
      end
   end

   // ------------------------------------------------------------------------
   // axi4-lite write path
   // ------------------------------------------------------------------------
   logic do_write;
   assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg  <= 1'b0;
         w_held_reg   <= 1'b0;
         aw_addr_reg  <= '0;
         w_data_reg   <= 32'h0000_0000;
         w_strb_reg   <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `T16_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_held_reg  <= 1'b0;
            w_held_reg   <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr_reg[7:0] > `T16_OFS_PRESCALE)
                            ? `T16_RESP_SLVERR : `T16_RESP_OKAY;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end
   // ready only while the slot is empty, so each channel is taken once
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end else begin
         s_axi_awready <= !aw_held_reg && !(s_axi_awvalid && s_axi_awready);
         s_axi_wready  <= !w_held_reg && !(s_axi_wvalid && s_axi_wready);
      end
   end

   // merge byte lanes of a 16-bit register with the write data
   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] d,
                                           input logic [3:0]  s);
      merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction

   logic wr_ctrl;
   logic wr_count;
   logic wr_cmp_a;
   logic wr_cmp_b;
   logic wr_cap;
   logic wr_flags;
   logic wr_pre;
   assign wr_ctrl  = do_write && (aw_addr_reg[7:0] == `T16_OFS_CTRL);
   assign wr_count = do_write && (aw_addr_reg[7:0] == `T16_OFS_COUNT);
   assign wr_cmp_a = do_write && (aw_addr_reg[7:0] == `T16_OFS_CMP_A);
   assign wr_cmp_b = do_write && (aw_addr_reg[7:0] == `T16_OFS_CMP_B);
   assign wr_cap   = do_write && (aw_addr_reg[7:0] == `T16_OFS_CAPTURE);
   assign wr_flags = do_write && (aw_addr_reg[7:0] == `T16_OFS_FLAGS);
   assign wr_pre   = do_write && (aw_addr_reg[7:0] == `T16_OFS_PRESCALE);

   // ------------------------------------------------------------------------
   // control, capture and prescale registers
   // ------------------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         waveform_mode_reg        <= 4'h0;
         output_action_mode_a_reg <= 2'h0;
         output_action_mode_b_reg <= 2'h0;
         capture_reg_reg          <= `T16_BOTTOM;
         prescale_div_reg         <= `T16_BOTTOM;
      end else begin
         if (wr_ctrl && w_strb_reg[0]) begin
            waveform_mode_reg        <= w_data_reg[`T16_WGM_LSB +: 4];
            output_action_mode_a_reg <= w_data_reg[`T16_COMA_LSB +: 2];
            output_action_mode_b_reg <= w_data_reg[`T16_COMB_LSB +: 2];
         end
         // unbuffered: a top below the count is missed until wrap
         if (wr_cap)
            capture_reg_reg <= merge16(capture_reg_reg, w_data_reg, w_strb_reg);
         if (wr_pre)
            prescale_div_reg <= merge16(prescale_div_reg, w_data_reg, w_strb_reg);
      end
   end

   // ------------------------------------------------------------------------
   // compare buffers and active compare registers
   // ------------------------------------------------------------------------
   logic load_point;
   assign load_point = tick && at_top && (is_fast || (is_pc && !count_down_reg));
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         compare_buf_a_reg <= `T16_BOTTOM;
         compare_buf_b_reg <= `T16_BOTTOM;
         compare_reg_a_reg <= `T16_BOTTOM;
         compare_reg_b_reg <= `T16_BOTTOM;
      end else begin
         if (wr_cmp_a)
            compare_buf_a_reg <= merge16(compare_buf_a_reg, w_data_reg, w_strb_reg)
                                 & fixed_mask;
         if (wr_cmp_b)
            compare_buf_b_reg <= merge16(compare_buf_b_reg, w_data_reg, w_strb_reg)
                                 & fixed_mask;
         if (!(is_fast || is_pc)) begin
            // non-pwm modes are unbuffered
            compare_reg_a_reg <= compare_buf_a_reg;
            compare_reg_b_reg <= compare_buf_b_reg;
         end else if (load_point) begin
            compare_reg_a_reg <= compare_buf_a_reg;
            compare_reg_b_reg <= compare_buf_b_reg;
         end
      end
   end

   // ------------------------------------------------------------------------
   // counter and direction
   // ------------------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         counter_value_reg <= `T16_BOTTOM;
         count_down_reg    <= 1'b0;
      end else if (wr_count) begin
         counter_value_reg <= merge16(counter_value_reg, w_data_reg, w_strb_reg);
      end else if (tick) begin
         if (is_fast) begin
            count_down_reg <= 1'b0;
            // past a missed top the count runs to max and wraps naturally
            if (at_top)
               counter_value_reg <= `T16_BOTTOM;
            else
               counter_value_reg <= counter_value_reg + 16'h0001;
         end else if (is_pc) begin
            // top and bottom each stand for one tick, so the turn adds no tick
            if (at_top && !count_down_reg)
               count_down_reg <= 1'b1;
            else if (count_down_reg && at_bottom)
               count_down_reg <= 1'b0;
            if ((count_down_reg && !at_bottom) || (at_top && !count_down_reg))
               counter_value_reg <= counter_value_reg - 16'h0001;
            else
               counter_value_reg <= counter_value_reg + 16'h0001;
         end
      end
   end

   // ------------------------------------------------------------------------
   // flags: hardware set wins over software write-one clear
   // ------------------------------------------------------------------------
   logic [3:0] flag_set;
   always_comb begin
      flag_set = 4'h0;
      if (tick) begin
         flag_set[`T16_FLAG_OVF]  = (is_fast && at_top)
                                  || (is_pc && at_bottom && count_down_reg);
         flag_set[`T16_FLAG_CMPA] = match_a || (load_point && top_is_cmpa);
         flag_set[`T16_FLAG_CMPB] = match_b;
         flag_set[`T16_FLAG_CAP]  = load_point && top_is_cap;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn)
         flags_reg <= 4'h0;
      else if (wr_flags && w_strb_reg[0])
         flags_reg <= (flags_reg & ~w_data_reg[3:0]) | flag_set;
      else
         flags_reg <= flags_reg | flag_set;
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         overflow_flag  <= 1'b0;
         compare_a_flag <= 1'b0;
         capture_flag   <= 1'b0;
      end else begin
         overflow_flag  <= flags_reg[`T16_FLAG_OVF];
         compare_a_flag <= flags_reg[`T16_FLAG_CMPA];
         capture_flag   <= flags_reg[`T16_FLAG_CAP];
      end
   end

   // ------------------------------------------------------------------------
   // output actions
   // ------------------------------------------------------------------------
   function automatic logic next_wave(input logic cur, input logic [1:0] act,
                                      input logic match, input logic fast,
                                      input logic pc, input logic top_hit,
                                      input logic down, input logic cmpa_top);
      logic inv;
      inv       = (act == timer16_pkg::ACT_SET);
      next_wave = cur;
      if (act == timer16_pkg::ACT_TOGGLE) begin
         if (cmpa_top && match)
            next_wave = ~cur;
      end else if (act != timer16_pkg::ACT_OFF) begin
         if (fast) begin
            // match wins over top, so compare equal to top gives a level
            if (match)
               next_wave = inv;
            else if (top_hit)
               next_wave = ~inv;
         end else if (pc && match) begin
            next_wave = down ? ~inv : inv;
         end
      end
   endfunction

   logic pc_down_eff;
   // a match at top counts as downward, so compare equal to top holds the level of a downward match
   assign pc_down_eff = (count_down_reg && !at_bottom) || at_top;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wave_out_a <= 1'b0;
         wave_out_b <= 1'b0;
      end else if (tick) begin
         wave_out_a <= next_wave(wave_out_a, output_action_mode_a_reg, match_a, is_fast,
                                 is_pc, at_top, pc_down_eff, top_is_cmpa);
         wave_out_b <= next_wave(wave_out_b, output_action_mode_b_reg, match_b, is_fast,
                                 is_pc, at_top, pc_down_eff, 1'b0);
      end
   end

   // ------------------------------------------------------------------------
   // axi4-lite read path
   // ------------------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `T16_RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `T16_RESP_OKAY;
            case (s_axi_araddr[7:0])
               `T16_OFS_CTRL:     s_axi_rdata <= {24'h000000, output_action_mode_b_reg,
                                                  output_action_mode_a_reg, waveform_mode_reg};
               `T16_OFS_COUNT:    s_axi_rdata <= {16'h0000, counter_value_reg};
               `T16_OFS_CMP_A:    s_axi_rdata <= {16'h0000, compare_buf_a_reg};
               `T16_OFS_CMP_B:    s_axi_rdata <= {16'h0000, compare_buf_b_reg};
               `T16_OFS_CAPTURE:  s_axi_rdata <= {16'h0000, capture_reg_reg};
               `T16_OFS_FLAGS:    s_axi_rdata <= {28'h0000000, flags_reg};
               `T16_OFS_PRESCALE: s_axi_rdata <= {16'h0000, prescale_div_reg};
               default: begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= `T16_RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// ---- bench/timer16_pwm_props.sv ----
// Purpose: port checker for timer16_pwm
// Assumes: one clock, synchronous active-low reset
// Notes:   a flag may only drop shortly after a register write
`timescale 1ns/1ns
`default_nettype none
module timer16_pwm_props (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        overflow_flag,
   input wire logic        compare_a_flag,
   input wire logic        capture_flag
);
   // ------------------------------------------------------------
   // helpers and properties
   // ------------------------------------------------------------
   logic [3:0] since_w;
   // cycles since the last write data handshake; saturates so an old write excuses nothing
   always_ff @(posedge aclk) begin
      if (!aresetn || (s_axi_wvalid && s_axi_wready)) begin
         since_w <= 4'h0;
      end else if (since_w != 4'hF) begin
         since_w <= since_w + 4'h1;
      end
   end
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   sequence s_wtake;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   // bus handshakes
   a_write_answer: assert property (s_wtake |-> ##[1:2] s_axi_bvalid)
      else $error("write response missing");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data missing");
   a_aw_refused: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
      else $error("address taken twice");
   a_bvalid_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response withdrawn");
   a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
      else $error("read data changed while waiting");
   // sticky event flags
   a_ovf_sticky: assert property ($fell(overflow_flag) |-> since_w < 4'h8)
      else $error("overflow flag dropped without a write");
   a_cmpa_sticky: assert property ($fell(compare_a_flag) |-> since_w < 4'h8)
      else $error("compare flag dropped without a write");
   a_cap_sticky: assert property ($fell(capture_flag) |-> since_w < 4'h8)
      else $error("capture flag dropped without a write");
endmodule
bind timer16_pwm timer16_pwm_props u_props (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .overflow_flag(overflow_flag),
   .compare_a_flag(compare_a_flag), .capture_flag(capture_flag));
`default_nettype wire

// ---- bench/testbench.sv ----
// Purpose: self-checking bench for timer16_pwm
// Assumes: top of four drives modes 10, 11, 14 and 15 through the axi4-lite bus
// Notes:   duty is measured as high cycles over whole periods
`timescale 1ns/1ns
`default_nettype none
`include "timer16_params.svh"
module testbench;
   logic        aclk    = 1'b0;
   logic        aresetn = 1'b0;
   logic [7:0]  awaddr  = 8'h00;
   logic [7:0]  araddr  = 8'h00;
   logic [31:0] wdata   = 32'h0;
   logic        awvalid = 1'b0;
   logic        wvalid  = 1'b0;
   logic        bready  = 1'b0, rready = 1'b0;
   logic        arvalid = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, wa, wb, ovf, cmpa, cap;
   logic [1:0]  r, rresp, bresp;
   logic [31:0] d, n, nb, rdata;
   int          k, err_total = 0, n_checks = 0;
   // mode, action, compare, expected high cycles in 80 clocks; top is 4
   logic [3:0]  tmd [9] = '{4'hE, 4'hE, 4'hA, 4'hA, 4'hA, 4'hA, 4'hA, 4'hF, 4'hB};
   logic [1:0]  tac [9] = '{2'h2, 2'h3, 2'h2, 2'h3, 2'h2, 2'h2, 2'h3, 2'h1, 2'h1};
   logic [15:0] tcm [9] = '{16'h2, 16'h2, 16'h1, 16'h1, 16'h0, 16'h4, 16'h0, 16'h4, 16'h4};
   logic [31:0] tex [9] = '{32'h30, 32'h20, 32'h14, 32'h3C, 32'h0, 32'h50, 32'h50, 32'h28, 32'h28};
   always #10 aclk = ~aclk;
   timer16_pwm #(.ADDR_W(8)) DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .wave_out_a(wa),
      .wave_out_b(wb), .overflow_flag(ovf), .compare_a_flag(cmpa), .capture_flag(cap));
   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   // a bounded wait that ran out ends the run
   task automatic tmo(input int i);
      if (i >= 200) begin
         err_total++;
         $display("ERROR bus wait expected answer seen none");
         stop_test();
      end
   endtask
   // address and data offered together, each released once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] dv);
      int i;
      @(posedge aclk);
      awaddr <= a;
      wdata <= dv;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (i = 0; i < 200 && !bvalid; i++) begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end
      bready <= 1'b0;
      tmo(i);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] dv, output logic [1:0] rv);
      int i;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (i = 0; i < 200 && !rvalid; i++) begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end
      dv = rdata;
      rv = rresp;
      rready <= 1'b0;
      tmo(i);
   endtask
   // counter is stopped and cleared first so it never sits above the new top
   task automatic cfg(input logic [3:0] m, input logic [1:0] a, input logic [15:0] c);
      wr(`T16_OFS_CTRL, 32'h0);
      wr(`T16_OFS_COUNT, 32'h0);
      wr(`T16_OFS_CAPTURE, 32'h4);
      wr(`T16_OFS_CMP_A, {16'h0, c});
      wr(`T16_OFS_CTRL, {24'h0, a, a, m});
   endtask
   // settle for one window, then count high cycles of both outputs over the next
   task automatic meas(input int w, output logic [31:0] c);
      c = 32'h0;
      nb = 32'h0;
      repeat (w) @(posedge aclk);
      repeat (w) begin
         @(posedge aclk);
         c = c + {31'h0, wa};
         nb = nb + {31'h0, wb};
      end
   endtask
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      wr(`T16_OFS_CTRL, 32'h5);
      wr(`T16_OFS_CMP_A, 32'h1234);
      check("bresp", {30'h0, bresp}, {30'h0, `T16_RESP_OKAY});
      rd(`T16_OFS_CMP_A, d, r);
      check("cmp_a", d, 32'h34);
      rd(8'h1C, d, r);
      check("rresp", {30'h0, r}, {30'h0, `T16_RESP_SLVERR});
      $display("test registers done");
      for (k = 0; k < 9; k++) begin
         cfg(tmd[k], tac[k], tcm[k]);
         meas(80, n);
         check("wave_a", n, tex[k]);
      end
      $display("test waveforms done");
      cfg(4'hE, 2'h2, 16'h4);
      meas(80, n);
      check("level", {31'h0, n == 32'h0 || n == 32'h50}, 32'h1);
      check("spike", nb, 32'h10);
      check("flags", {29'h0, ovf, cap, cmpa}, 32'h7);
      cfg(4'h0, 2'h0, 16'h4);
      wr(`T16_OFS_FLAGS, 32'hF);
      repeat (4) @(posedge aclk);
      check("flags", {29'h0, ovf, cap, cmpa}, 32'h0);
      cfg(4'hF, 2'h1, 16'h4);
      meas(80, n);
      check("flags", {29'h0, ovf, cap, cmpa}, 32'h5);
      $display("test flags done");
      wr(`T16_OFS_PRESCALE, 32'h1);
      cfg(4'hE, 2'h2, 16'h2);
      meas(160, n);
      check("wave_a", n, 32'h60);
      $display("test prescale done");
      stop_test();
   end
endmodule
`default_nettype wire
